// *** logic/lie_edge.sv ***
// lie_edge: rising edge detector for a vector of event sources.
// assumes sources are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module lie_edge #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [W-1:0] lvl,
   output logic [W-1:0] rise
);
   logic [W-1:0] prev_r;

   // previous level kept so a held-high source fires only once
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prev_r <= '0;
      end else begin
         prev_r <= lvl; // [R19]
      end
   end

   assign rise = lvl & ~prev_r; // [R19]
endmodule
`default_nettype wire

// *** logic/lie_pkg.sv ***
// lie_pkg: constants and carrier types for the link interrupt event logic.
// assumes a single core_clk domain and a plain strobe register port.
package lie_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] EVT_SET_OFS = 8'h80;
   localparam logic [7:0] EVT_CLR_OFS = 8'h84;
   localparam logic [7:0] MASK_SET_OFS = 8'h88;
   localparam logic [7:0] MASK_CLR_OFS = 8'h8C;
   localparam logic [7:0] CTRL_OFS = 8'h90;
   localparam logic [7:0] PHY_DATA_OFS = 8'hEC;
   localparam logic [7:0] RAW_EVT_OFS = 8'h94;
   localparam logic [7:0] CTX_BLOCK_OFS = 8'h98;

   // ------------------------------------------------------------------
   // event bit positions
   // ------------------------------------------------------------------
   localparam int BIT_RSVD31 = 31;
   localparam int BIT_VENDOR = 30;
   localparam int BIT_SOFT = 29;
   localparam int BIT_RSVD28 = 28;
   localparam int BIT_LATE_ACK = 27;
   localparam int BIT_PHY_BYTE = 26;
   localparam int BIT_OVERLONG = 25;
   localparam int BIT_FATAL = 24;
   localparam int BIT_MISMATCH = 23;
   localparam int BIT_NEW_ISO = 20;
   localparam int BIT_REINIT = 17;
   localparam int BIT_SCAN_DONE = 16;
   localparam int BIT_ISO_RX = 7;
   localparam int BIT_ISO_TX = 6;
   localparam int CTRL_LATE_ACK_EN = 29;
   localparam int CTRL_TIMING_ROOT = 21;
   localparam int PHY_DATA_LSB = 16;

   // bits held zero in the event register; 31, 28 and 14:10 read zero, 7 and 6 read the unlatched iso summaries
   localparam logic [31:0] EVT_READ_ZERO = 32'h9000_7CC0;
   localparam logic [31:0] EVT_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int OVERLONG_US = 125;
   localparam int OVERLONG_CYC = (OVERLONG_US * 1000) / CLK_PERIOD_NS;
   localparam int SECS_W = 7;
   localparam int CYCS_W = 13;
   localparam int NCTX = 4;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } lie_req_t;

   typedef struct packed {
      logic rx_fifo_pending;
      logic phys_resp_busy;
      logic tardy_ack_sent;
      logic phy_byte_valid;
      logic [7:0] phy_byte;
      logic cyc_start_tx;
      logic subaction_gap_end;
      logic cyc_start_rx;
      logic [SECS_W-1:0] rx_secs;
      logic [CYCS_W-1:0] rx_cycles;
      logic [SECS_W-1:0] timer_secs_field;
      logic [CYCS_W-1:0] timer_cycles_field;
      logic link_reinit;
      logic node_id_scan_done;
      logic vendor_src;
      logic [NCTX-1:0] ctx_dead;
      logic [NCTX-1:0] ctx_irq;
      logic [15:0] low_src;
   } lie_src_t;
endpackage

// *** logic/lie_top.sv ***
// lie_top: interrupt event set/clear register with mask and one irq line.
// assumes a plain register port with read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R01: source rising edge or set write sets bit
// R02: clear-view ones clear a bit; a reinit edge also clears bit 16
// R03: event read returns events AND mask
// R04: bits 31 and 28 always read zero
// R05: software never writes vendor bit 30
// R06: bit 29 changed only by software
// R07: late ack needs control enable bit 29
// R08: fifo pending, response busy, tardy ack
// R09: phy byte sets 26, readable at 23:16
// R10: overlong cycle over 125 us sets 25
// R11: overlong cycle clears timing root enable
// R12: dead context sets fatal fault 24
// R13: fatal fault blocks faulting contexts' interrupts
// R14: cycle start timer mismatch sets 23
// R15: cycle count low bit toggle sets 20
// R16: reinit event clears scan done bit
// R17: iso summaries are unlatched masked ORs
// R18: irq high while any masked event set
// R19: edge detect on previous registered level
module lie_top
   import lie_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire lie_req_t req,
   input wire lie_src_t src,
   input wire logic [7:0] iso_rx_evt,
   input wire logic [7:0] iso_tx_evt,
   output logic [31:0] rdata,
   output logic irq,
   output logic timing_root_enable,
   output logic late_ack_event_enable,
   output logic [NCTX-1:0] ctx_irq_out
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [31:0] evt_r;
   logic [31:0] evt_nxt;
   logic [31:0] mask_r;
   logic [31:0] ctrl_r;
   logic [7:0] phy_data_r;
   logic [NCTX-1:0] ctx_evt_r;
   logic [NCTX-1:0] blocked_r;
   logic [7:0] iso_rx_mask_r;
   logic [7:0] iso_tx_mask_r;
   logic [31:0] rdata_r;
   logic [17:0] gap_cnt_r;
   logic timing_run_r;
   logic cyc_lsb_prev_r;
   logic [31:0] masked;
   logic [31:0] hw_set;
   logic [31:0] ext_lvl;
   logic [31:0] ext_rise;
   logic late_busy;
   logic mismatch;
   logic overlong;
   logic iso_rx_sum;
   logic iso_tx_sum;
   logic cyc_toggle;
   logic wr_evt_set;
   logic wr_evt_clr;

   function automatic logic hit(input lie_req_t r, input logic [7:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction

   assign wr_evt_set = hit(req, EVT_SET_OFS);
   assign wr_evt_clr = hit(req, EVT_CLR_OFS);

   // ------------------------------------------------------------------
   // source conditioning
   // ------------------------------------------------------------------
   assign late_busy = src.rx_fifo_pending | src.phys_resp_busy | src.tardy_ack_sent; // [R08]
   assign mismatch = src.cyc_start_rx &&
      ((src.rx_secs != src.timer_secs_field) ||
       (src.rx_cycles != src.timer_cycles_field)); // [R14]
   assign cyc_toggle = src.timer_cycles_field[0] ^ cyc_lsb_prev_r; // [R15]

   always_comb begin
      ext_lvl = 32'h0000_0000;
      ext_lvl[15:0] = src.low_src;
      ext_lvl[BIT_VENDOR] = src.vendor_src;
      ext_lvl[BIT_LATE_ACK] = late_busy && ctrl_r[CTRL_LATE_ACK_EN]; // [R07]
      ext_lvl[BIT_PHY_BYTE] = src.phy_byte_valid; // [R09]
      ext_lvl[BIT_FATAL] = |src.ctx_dead; // [R12]
      ext_lvl[BIT_MISMATCH] = mismatch; // [R14]
      ext_lvl[BIT_REINIT] = src.link_reinit;
      ext_lvl[BIT_SCAN_DONE] = src.node_id_scan_done;
   end

   lie_edge #(
      .W(32)
   ) i_lie_edge (
      .core_clk(core_clk),
      .rstn(rstn),
      .lvl(ext_lvl),
      .rise(ext_rise)
   );

   always_comb begin
      hw_set = ext_rise & ~EVT_READ_ZERO; // [R04]
      hw_set[BIT_SOFT] = 1'b0; // [R06]
      hw_set[BIT_OVERLONG] = overlong; // [R10]
      hw_set[BIT_NEW_ISO] = cyc_toggle; // [R15]
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cyc_lsb_prev_r <= 1'b0;
      end else begin
         cyc_lsb_prev_r <= src.timer_cycles_field[0];
      end
   end

   // ------------------------------------------------------------------
   // overlong cycle timer
   // ------------------------------------------------------------------
   // counts from cycle start transmit until the following subaction gap end
   // enable gates the compare so a software stop at the limit cannot still fire
   assign overlong = timing_run_r && ctrl_r[CTRL_TIMING_ROOT] &&
      (gap_cnt_r == 18'(OVERLONG_CYC)); // [R10]

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         timing_run_r <= 1'b0;
         gap_cnt_r <= '0;
      end else if (!ctrl_r[CTRL_TIMING_ROOT] || src.subaction_gap_end || overlong) begin
         timing_run_r <= src.cyc_start_tx && ctrl_r[CTRL_TIMING_ROOT] && !overlong;
         gap_cnt_r <= '0;
      end else if (src.cyc_start_tx) begin
         timing_run_r <= 1'b1;
         gap_cnt_r <= '0;
      end else if (timing_run_r) begin
         gap_cnt_r <= gap_cnt_r + 18'd1;
      end
   end

   // ------------------------------------------------------------------
   // event register
   // ------------------------------------------------------------------
   always_comb begin
      evt_nxt = evt_r;
      if (wr_evt_clr) begin
         evt_nxt = evt_nxt & ~req.wdata; // [R02]
      end
      if (ext_rise[BIT_REINIT]) begin
         evt_nxt[BIT_SCAN_DONE] = 1'b0; // [R16]
      end
      // sets after the clear write so an event in the clearing cycle is kept; a reinit edge still clears bit 16
      evt_nxt = evt_nxt | hw_set; // [R01]
      if (ext_rise[BIT_REINIT]) begin
         evt_nxt[BIT_SCAN_DONE] = 1'b0; // [R16]
      end
      if (wr_evt_set) begin
         evt_nxt = evt_nxt | req.wdata; // [R01]
      end
      evt_nxt = evt_nxt & ~EVT_READ_ZERO; // [R04] [R17]
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         evt_r <= EVT_RESET;
      end else begin
         evt_r <= evt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // context events, blocked while fatal fault stands
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctx_evt_r <= '0;
         blocked_r <= '0;
      end else begin
         blocked_r <= evt_nxt[BIT_FATAL] ? (blocked_r | src.ctx_dead) : '0;
         ctx_evt_r <= ctx_evt_r | (src.ctx_irq & ~blocked_r & ~src.ctx_dead); // [R13]
         if (hit(req, CTX_BLOCK_OFS)) begin
            ctx_evt_r <= (ctx_evt_r & ~req.wdata[NCTX-1:0]) |
               (src.ctx_irq & ~blocked_r & ~src.ctx_dead);
         end
      end
   end
   assign ctx_irq_out = ctx_evt_r;

   // ------------------------------------------------------------------
   // mask, control, phy data
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= MASK_RESET;
         iso_rx_mask_r <= '0;
         iso_tx_mask_r <= '0;
      end else begin
         if (hit(req, MASK_SET_OFS)) begin
            mask_r <= mask_r | req.wdata;
         end else if (hit(req, MASK_CLR_OFS)) begin
            mask_r <= mask_r & ~req.wdata;
         end
         if (hit(req, RAW_EVT_OFS)) begin
            iso_rx_mask_r <= req.wdata[15:8];
            iso_tx_mask_r <= req.wdata[7:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         if (hit(req, CTRL_OFS)) begin
            ctrl_r <= req.wdata;
         end
         if (overlong) begin
            ctrl_r[CTRL_TIMING_ROOT] <= 1'b0; // [R11]
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phy_data_r <= '0;
      end else if (src.phy_byte_valid) begin
         phy_data_r <= src.phy_byte; // [R09]
      end
   end

   assign timing_root_enable = ctrl_r[CTRL_TIMING_ROOT];
   assign late_ack_event_enable = ctrl_r[CTRL_LATE_ACK_EN];

   // ------------------------------------------------------------------
   // masked view, summaries, interrupt, read port
   // ------------------------------------------------------------------
   assign iso_rx_sum = |(iso_rx_evt & iso_rx_mask_r); // [R17]
   assign iso_tx_sum = |(iso_tx_evt & iso_tx_mask_r); // [R17]

   always_comb begin
      masked = evt_r & mask_r; // [R03]
      masked[BIT_ISO_RX] = iso_rx_sum & mask_r[BIT_ISO_RX];
      masked[BIT_ISO_TX] = iso_tx_sum & mask_r[BIT_ISO_TX];
      masked[BIT_RSVD31] = 1'b0; // [R04]
      masked[BIT_RSVD28] = 1'b0; // [R04]
   end

   assign irq = |masked; // [R18]

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= '0;
      end else if (req.rd) begin
         case (req.addr)
            EVT_SET_OFS, EVT_CLR_OFS: rdata_r <= masked; // [R03]
            MASK_SET_OFS, MASK_CLR_OFS: rdata_r <= mask_r;
            CTRL_OFS: rdata_r <= ctrl_r;
            PHY_DATA_OFS: rdata_r <= {8'h00, phy_data_r, 16'h0000}; // [R09]
            RAW_EVT_OFS: rdata_r <= {16'h0000, iso_rx_mask_r, iso_tx_mask_r};
            CTX_BLOCK_OFS: rdata_r <= {24'h00_0000, blocked_r, ctx_evt_r};
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end
   assign rdata = rdata_r;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   evt_clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R02]
      (evt_r[BIT_SOFT] && !(wr_evt_clr && req.wdata[BIT_SOFT])) |=> evt_r[BIT_SOFT])
      else $error("event bit dropped without clear");
   soft_set_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R01]
      (wr_evt_set && req.wdata[BIT_SOFT]) |=> evt_r[BIT_SOFT])
      else $error("set write did not set bit");
   read_masked_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R03]
      (req.rd && req.addr == EVT_SET_OFS) |=> rdata == $past(masked))
      else $error("event read not masked");
   rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R04]
      !evt_r[BIT_RSVD31] && !evt_r[BIT_RSVD28])
      else $error("reserved event bit set");
   soft_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R06]
      (!evt_r[BIT_SOFT] && !(wr_evt_set && req.wdata[BIT_SOFT])) |=> !evt_r[BIT_SOFT])
      else $error("soft bit set by hardware");
   late_ack_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R07]
      (!ctrl_r[CTRL_LATE_ACK_EN] && !evt_r[BIT_LATE_ACK] && !wr_evt_set)
      ##1 !ctrl_r[CTRL_LATE_ACK_EN] |-> !evt_r[BIT_LATE_ACK])
      else $error("late ack set while disabled");
   root_clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R11]
      overlong |=> !timing_root_enable && evt_r[BIT_OVERLONG])
      else $error("overlong did not clear root enable");
   scan_clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R16]
      (ext_rise[BIT_REINIT] && !wr_evt_set) |=> !evt_r[BIT_SCAN_DONE] && evt_r[BIT_REINIT])
      else $error("scan done not cleared on reinit");
   irq_level_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R18]
      irq == ((evt_r & mask_r & ~32'h0000_00C0) != 32'h0000_0000 ||
              masked[BIT_ISO_RX] || masked[BIT_ISO_TX]))
      else $error("irq does not follow masked events");

   // ------------------------------------------------------------------
   // checks on sources and read path
   // ------------------------------------------------------------------
   // no bit may drop unless a clear write or a reinit edge is taken
   no_drop_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R02]
      (!wr_evt_clr && !ext_rise[BIT_REINIT]) |=> ((evt_r & $past(evt_r)) == $past(evt_r)))
      else $error("event bit dropped without clear write");
   read_rsvd_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R04]
      (req.rd && (req.addr == EVT_SET_OFS || req.addr == EVT_CLR_OFS))
      |=> !rdata[BIT_RSVD31] && !rdata[BIT_RSVD28])
      else $error("reserved bit read as one");
   late_busy_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R08]
      (ctrl_r[CTRL_LATE_ACK_EN] &&
       $rose(src.rx_fifo_pending | src.phys_resp_busy | src.tardy_ack_sent))
      |=> evt_r[BIT_LATE_ACK])
      else $error("busy condition did not set late ack");
   phy_event_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R09]
      $rose(src.phy_byte_valid)
      |=> evt_r[BIT_PHY_BYTE] && phy_data_r == $past(src.phy_byte))
      else $error("phy byte not captured");
   overlong_gate_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R10]
      (!evt_r[BIT_OVERLONG] && !timing_root_enable && !wr_evt_set) |=> !evt_r[BIT_OVERLONG])
      else $error("overlong set while root disabled");
   fatal_set_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
      $rose(|src.ctx_dead) |=> evt_r[BIT_FATAL])
      else $error("dead context did not set fatal fault");
   ctx_block_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
      evt_r[BIT_FATAL] |=> ((ctx_evt_r & $past(blocked_r & ~ctx_evt_r)) == 4'h0))
      else $error("blocked context event was set");
   mismatch_set_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
      $rose(src.cyc_start_rx && ((src.rx_secs != src.timer_secs_field) ||
         (src.rx_cycles != src.timer_cycles_field)))
      |=> evt_r[BIT_MISMATCH])
      else $error("timer mismatch not flagged");
   new_iso_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
      $changed(src.timer_cycles_field[0]) |=> evt_r[BIT_NEW_ISO])
      else $error("cycle toggle did not set new period");
   iso_rx_live_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R17]
      (iso_rx_evt == 8'h00) |-> !masked[BIT_ISO_RX])
      else $error("receive summary held without source");
   iso_tx_live_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R17]
      (iso_tx_evt == 8'h00) |-> !masked[BIT_ISO_TX])
      else $error("transmit summary held without source");
   held_once_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R19]
      (ctrl_r[CTRL_LATE_ACK_EN] && $past(ctrl_r[CTRL_LATE_ACK_EN]) && late_busy &&
       $past(late_busy) && !evt_r[BIT_LATE_ACK] && !wr_evt_set)
      |=> !evt_r[BIT_LATE_ACK])
      else $error("held source set its bit again");
endmodule
`default_nettype wire

// *** tb/lie_host_model.sv ***
// lie_host_model: host software side of the event register port.
// assumes the bench calls its tasks at a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module lie_host_model
   import lie_pkg::*;
(
   input wire logic core_clk,
   output var lie_req_t req,
   input wire logic [31:0] rdata
);
   initial begin
      req = '0;
   end

   // ------------------------------------------------------------------
   // bus cycles: one strobe cycle, then one idle cycle
   // ------------------------------------------------------------------
   // the idle cycle keeps two transfers from assigning req in one step
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      v = d;
      if (a == EVT_SET_OFS || a == EVT_CLR_OFS) begin
         v[BIT_VENDOR] = 1'b0;
      end
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req <= '0;
      @(posedge core_clk);
   endtask

   // read data stand only in the cycle after the strobe is taken
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      req <= '0;
      #1;
      d = rdata;
      @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// *** tb/tb_link_interrupt_event_logic.sv ***
// tb_link_interrupt_event_logic: register level tests of the event logic.
// assumes lie_top and lie_host_model; one 100 MHz clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module tb_link_interrupt_event_logic
   import lie_pkg::*;
;
   logic core_clk;
   logic rstn;
   lie_req_t req;
   lie_src_t src;
   logic [7:0] iso_rx_evt;
   logic [7:0] iso_tx_evt;
   logic [31:0] rdata;
   logic irq;
   logic timing_root_enable;
   logic late_ack_event_enable;
   logic [NCTX-1:0] ctx_irq_out;
   int miscompares;
   int cmp_count;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;

   lie_top i_lie_top (.core_clk(core_clk), .rstn(rstn), .req(req), .src(src),
      .iso_rx_evt(iso_rx_evt), .iso_tx_evt(iso_tx_evt), .rdata(rdata), .irq(irq),
      .timing_root_enable(timing_root_enable), .late_ack_event_enable(late_ack_event_enable),
      .ctx_irq_out(ctx_irq_out));
   lie_host_model i_lie_host_model (.core_clk(core_clk), .req(req), .rdata(rdata));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_lie_host_model.wr_reg(a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] keep, input logic [31:0] exp,
                       input string what);
      logic [31:0] v;
      i_lie_host_model.rd_reg(a, v);
      check(what, v & keep, exp);
   endtask

   task automatic set_busy(input int i, input logic v);
      case (i)
         0: src.rx_fifo_pending <= v;
         1: src.phys_resp_busy <= v;
         default: src.tardy_ack_sent <= v;
      endcase
   endtask

   task automatic cyc_rx(input logic [6:0] s, input logic [12:0] c, input logic [31:0] exp);
      src.rx_secs <= s;
      src.rx_cycles <= c;
      src.cyc_start_rx <= 1'b1;
      tick(1);
      src.cyc_start_rx <= 1'b0;
      tick(2);
      rchk(EVT_SET_OFS, 32'h0080_0000, exp, "cycle start mismatch");
      wr(EVT_CLR_OFS, 32'h0080_0000);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // hang guard: the tests need about 12900 cycles
   initial begin
      #400_000;
      miscompares++;
      report_and_stop();
   end

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      miscompares = 0;
      cmp_count = 0;
      rstn = 1'b0;
      src = '0;
      iso_rx_evt = 8'h00;
      iso_tx_evt = 8'h00;
      tick(3);
      rstn <= 1'b1;
      tick(1);
      wr(MASK_SET_OFS, ALL);
      wr(RAW_EVT_OFS, 32'h0000_FFFF);

      wr(EVT_SET_OFS, 32'h2000_0000);
      rchk(EVT_SET_OFS, ALL, 32'h2000_0000, "soft event set");
      check("irq raised", {31'd0, irq}, 32'h1);
      wr(EVT_CLR_OFS, 32'h0000_0000);
      rchk(EVT_CLR_OFS, ALL, 32'h2000_0000, "zero clear write");
      wr(MASK_CLR_OFS, 32'h2000_0000);
      rchk(EVT_SET_OFS, ALL, 32'h0000_0000, "masked read");
      check("irq masked", {31'd0, irq}, 32'h0);
      wr(MASK_SET_OFS, 32'h2000_0000);
      check("irq unmasked", {31'd0, irq}, 32'h1);
      wr(EVT_CLR_OFS, 32'h2000_0000);
      rchk(EVT_SET_OFS, ALL, 32'h0000_0000, "soft event clear");
      check("irq dropped", {31'd0, irq}, 32'h0);
      $display("test soft event done");

      wr(EVT_SET_OFS, 32'h9000_7C00);
      rchk(EVT_SET_OFS, 32'h9000_0000, 32'h0000_0000, "reserved bits");
      rchk(8'h40, ALL, 32'h0000_0000, "unmapped read");
      $display("test reserved done");

      set_busy(0, 1'b1);
      tick(3);
      rchk(EVT_SET_OFS, 32'h0800_0000, 32'h0000_0000, "late ack disabled");
      set_busy(0, 1'b0);
      wr(CTRL_OFS, 32'h2000_0000);
      check("late ack enable", {31'd0, late_ack_event_enable}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         set_busy(i, 1'b1);
         tick(3);
         rchk(EVT_SET_OFS, 32'h0800_0000, 32'h0800_0000, "late ack source");
         wr(EVT_CLR_OFS, 32'h0800_0000);
         tick(3);
         rchk(EVT_SET_OFS, 32'h0800_0000, 32'h0000_0000, "held source once");
         set_busy(i, 1'b0);
         tick(1);
      end
      wr(CTRL_OFS, 32'h0000_0000);
      $display("test late ack done");

      src.phy_byte <= 8'hA5;
      src.phy_byte_valid <= 1'b1;
      tick(1);
      src.phy_byte_valid <= 1'b0;
      tick(2);
      rchk(EVT_SET_OFS, 32'h0400_0000, 32'h0400_0000, "phy byte event");
      rchk(PHY_DATA_OFS, 32'h00FF_0000, 32'h00A5_0000, "phy byte data");
      $display("test phy byte done");

      src.timer_secs_field <= 7'h05;
      src.timer_cycles_field <= 13'h0100;
      tick(3);
      wr(EVT_CLR_OFS, 32'h0010_0000);
      cyc_rx(7'h05, 13'h0100, 32'h0000_0000);
      cyc_rx(7'h05, 13'h0101, 32'h0080_0000);
      cyc_rx(7'h06, 13'h0100, 32'h0080_0000);
      $display("test cycle mismatch done");

      rchk(EVT_SET_OFS, 32'h0010_0000, 32'h0000_0000, "no new period");
      src.timer_cycles_field <= 13'h0101;
      tick(3);
      rchk(EVT_SET_OFS, 32'h0010_0000, 32'h0010_0000, "new period");
      $display("test new period done");

      src.node_id_scan_done <= 1'b1;
      tick(3);
      rchk(EVT_SET_OFS, 32'h0003_0000, 32'h0001_0000, "scan done");
      src.link_reinit <= 1'b1;
      tick(3);
      rchk(EVT_SET_OFS, 32'h0003_0000, 32'h0002_0000, "reinit clears scan");
      $display("test reinit done");

      iso_rx_evt <= 8'h04;
      tick(2);
      rchk(EVT_SET_OFS, 32'h0000_00C0, 32'h0000_0080, "iso rx summary");
      iso_rx_evt <= 8'h00;
      iso_tx_evt <= 8'h80;
      tick(2);
      rchk(EVT_SET_OFS, 32'h0000_00C0, 32'h0000_0040, "iso tx summary");
      iso_tx_evt <= 8'h00;
      tick(2);
      rchk(EVT_SET_OFS, 32'h0000_00C0, 32'h0000_0000, "summary not held");
      $display("test iso summary done");

      src.ctx_dead <= 4'h1;
      tick(3);
      rchk(EVT_SET_OFS, 32'h0100_0000, 32'h0100_0000, "fatal fault");
      rchk(CTX_BLOCK_OFS, 32'h0000_00F0, 32'h0000_0010, "context blocked");
      // context recovered: only the block itself may now hold its events back
      src.ctx_dead <= 4'h0;
      src.ctx_irq <= 4'h1;
      tick(1);
      src.ctx_irq <= 4'h0;
      tick(2);
      check("blocked context irq", {28'd0, ctx_irq_out}, 32'h0);
      wr(EVT_CLR_OFS, 32'h0100_0000);
      rchk(CTX_BLOCK_OFS, 32'h0000_00F0, 32'h0000_0000, "context released");
      src.ctx_irq <= 4'h1;
      tick(1);
      src.ctx_irq <= 4'h0;
      tick(2);
      check("unblocked context irq", {28'd0, ctx_irq_out}, 32'h1);
      $display("test fatal fault done");

      wr(CTRL_OFS, 32'h0020_0000);
      check("root enable on", {31'd0, timing_root_enable}, 32'h1);
      src.cyc_start_tx <= 1'b1;
      tick(1);
      src.cyc_start_tx <= 1'b0;
      tick(100);
      src.subaction_gap_end <= 1'b1;
      tick(1);
      src.subaction_gap_end <= 1'b0;
      tick(3);
      rchk(EVT_SET_OFS, 32'h0200_0000, 32'h0000_0000, "short cycle");
      src.cyc_start_tx <= 1'b1;
      tick(1);
      src.cyc_start_tx <= 1'b0;
      tick(12400);
      rchk(EVT_SET_OFS, 32'h0200_0000, 32'h0000_0000, "cycle near limit");
      check("root enable kept", {31'd0, timing_root_enable}, 32'h1);
      tick(200);
      rchk(EVT_SET_OFS, 32'h0200_0000, 32'h0200_0000, "overlong cycle");
      check("root enable cleared", {31'd0, timing_root_enable}, 32'h0);
      $display("test overlong done");
      report_and_stop();
   end
endmodule
`default_nettype wire
